/* File: core/dae_pkg.sv */
// Purpose: Shared constants for the disk adapter error detection block
// Assumes: 40 MHz clock, 32-bit register port with 8-bit byte address
// Notes: Register offsets are byte addresses, one word each
package dae_pkg;
  // Register offsets
  localparam logic [7:0] OFS_BASIC = 8'h00; // Basic status, clear on read
  localparam logic [7:0] OFS_CBP = 8'h04; // Command block processor status, clear on read
  localparam logic [7:0] OFS_SEEK = 8'h08; // Seek status, clear on read
  localparam logic [7:0] OFS_ISTAT = 8'h0c; // Interrupt status, write one to clear
  localparam logic [7:0] OFS_IMASK = 8'h10; // Interrupt mask
  localparam logic [7:0] OFS_CTRL = 8'h14; // Control and multisector setup
  localparam logic [7:0] OFS_RESID = 8'h18; // Residual count and multisector state
  localparam logic [7:0] OFS_REV = 8'h1c; // Last measured revolution in cycles
  // Basic status bit positions
  localparam int BS_SNF = 0; // Sector not found
  localparam int BS_FILE = 1; // File error
  localparam int BS_CRC = 2; // CRC error
  localparam int BS_ID = 3; // ID error
  localparam int BS_DATA = 4; // Data field error
  localparam int BS_MS = 5; // Multisector error
  localparam int BS_CMD = 6; // Command error
  localparam int BS_PAR = 7; // Control bus parity error
  localparam int BS_PCI = 8; // Program-controlled interrupt seen
  localparam int BS_SPEED = 9; // Rotational speed ok (live)
  localparam int BS_TIME = 10; // Multisector read out of time window
  localparam int BS_W = 11;
  // Processor and seek status bit positions
  localparam int CB_FILE = 0;
  localparam int CB_PAR = 1;
  localparam int CB_PCI = 2;
  localparam int CB_W = 3;
  localparam int SK_CMD = 0;
  localparam int SK_CYL = 1;
  localparam int SK_W = 2;
  // Interrupt status bit positions
  localparam int IS_ERR = 0;
  localparam int IS_PCI = 1;
  localparam int IS_SPEED = 2;
  localparam int IS_MSDONE = 3;
  localparam int IS_W = 4;
  // Control register fields
  localparam int CT_RESET = 0; // Reset command, self clearing
  localparam int CT_START = 1; // Start multisector operation
  localparam int CT_SKIP_LO = 2; // Skip code, factor is 1 << code
  localparam int CT_CNT_LO = 4; // Sector count, 1 to 64
  localparam int CT_SECT_LO = 11; // First sector of operation
  // Reset values
  localparam logic [IS_W-1:0] IMASK_RST = 4'h0;
  // Decoded limits
  localparam logic [6:0] SNF_LO = 7'h42; // First sector address not on a track
  localparam logic [6:0] SNF_HI = 7'h7f;
  localparam logic [8:0] MAX_CYL = 9'h167; // Highest valid cylinder, 359
  localparam logic [6:0] MS_MAX_CNT = 7'h40; // 64 sectors per operation
  localparam logic [6:0] MS_TIMED_CNT = 7'h20; // 32-sector reads are timed
  // Times and cycle counts
  localparam int CLK_KHZ = 40000;
  localparam int REV_US = 19200; // One revolution
  localparam int REV_CYC = REV_US * CLK_KHZ / 1000;
  localparam int REV_MIN_CYC = (REV_CYC * 9 + 9) / 10; // Minus 10 percent, rounded up
  localparam int REV_MAX_CYC = REV_CYC * 11 / 10; // Plus 10 percent, rounded down
  localparam int MS_MIN_US = 40000;
  localparam int MS_MAX_US = 60000;
  localparam int MS_MIN_CYC = MS_MIN_US * (CLK_KHZ / 1000);
  localparam int MS_MAX_CYC = MS_MAX_US * (CLK_KHZ / 1000);
  // Multisector sequencer states
  typedef enum logic [0:0] {MS_IDLE = 1'b0, MS_RUN = 1'b1} dae_ms_t;
endpackage

/* File: core/dae_core.sv */
// Purpose: Error detection and status reporting of a disk storage adapter
// Assumes: Event strobes come from adapter logic on CLK; only INDEX_PIN is asynchronous
// Notes: Status reads clear the read register; interrupt status is write one to clear
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
//
// Summary of operation
// [RULE_01] Sector address 42..7F sets sector not found
// [RULE_02] Seek above top cylinder flags file error
// [RULE_03] Host treats cylinders 0..359 as valid
// [RULE_04] Even parity control byte flags file error
// [RULE_05] Odd readback under even check flags parity
// [RULE_06] Diagnostic write during busy chain: command error
// [RULE_07] PCI returns to host, chain keeps running
// [RULE_08] Bad ID CRC flags CRC and ID
// [RULE_09] Bad data CRC flags CRC and data
// [RULE_10] Protected sector write refused, data error
// [RULE_11] Mismatched recorded ID flags ID error
// [RULE_12] Nonzero residual at end flags multisector error
// [RULE_13] Multisector ID write touches requested IDs only
// [RULE_14] Skip factors 1,2,4,8; up to 64 sectors
// [RULE_15] 32-sector read finishes in 40..60 ms
// [RULE_16] Revolution 19.2 ms within 10 percent
// [RULE_17] Host decodes head configuration option byte
// [RULE_18] Errors stay latched until read or reset
module dae_core import dae_pkg::*; #(
  parameter int REV_MIN = REV_MIN_CYC,
  parameter int REV_MAX = REV_MAX_CYC,
  parameter int MS_MIN = MS_MIN_CYC,
  parameter int MS_MAX = MS_MAX_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  // Sector access and seek
  input wire logic SECT_ACC,
  input wire logic [6:0] SECT_ADDR,
  input wire logic SEEK_REQ,
  input wire logic [8:0] SEEK_CYL,
  // Control bus
  input wire logic CTL_SEND,
  input wire logic [7:0] CTL_BYTE,
  input wire logic CTL_PAR,
  input wire logic CTL_RB,
  input wire logic [7:0] RB_BYTE,
  input wire logic RB_PAR,
  // Command block chain
  input wire logic DIAG_WR,
  input wire logic CHAIN_BUSY,
  input wire logic PCI_ELEM,
  output logic PCI_RETURN,
  // Field checks
  input wire logic ID_CRC_BAD,
  input wire logic DATA_CRC_BAD,
  input wire logic ID_MISMATCH,
  input wire logic WR_REQ,
  input wire logic SECT_PROT,
  output logic WR_GATE,
  // Multisector
  input wire logic MS_SECT_DONE,
  input wire logic MS_END,
  input wire logic ID_WR_REQ,
  input wire logic [6:0] ID_WR_SECT,
  output logic ID_WR_GATE,
  output logic MS_BUSY,
  // Drive index pulse, asynchronous
  input wire logic INDEX_PIN,
  output logic SPEED_OK
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [BS_W-1:0] bs_r; // Basic status
  logic [CB_W-1:0] cb_r; // Processor status
  logic [SK_W-1:0] sk_r; // Seek status
  logic [IS_W-1:0] is_r; // Interrupt status
  logic [IS_W-1:0] im_r; // Interrupt mask
  logic [BS_W-1:0] bs_set; // Events this cycle
  logic [CB_W-1:0] cb_set;
  logic [SK_W-1:0] sk_set;
  logic [IS_W-1:0] is_set;
  logic wr_ctrl, rst_cmd, ms_start, cnt_ok;
  logic [6:0] cfg_cnt, cfg_sect;
  logic [1:0] cfg_skip;
  dae_ms_t ms_r; // Multisector sequencer
  logic [6:0] resid_r; // Residual count
  logic [6:0] next_r; // Next sector allowed for an ID write
  logic [6:0] skip_r; // Active skip factor
  logic [6:0] len_r; // Count loaded at start
  logic [23:0] ms_tmr_r; // Operation timer
  logic [2:0] idx_s_r; // Index synchroniser
  logic idx_f_r; // Filtered index level
  logic [23:0] rev_r; // Revolution counter
  logic [23:0] rev_last_r; // Last revolution length
  logic rev_seen_r; // One edge seen, period valid next time
  logic ms_end_err, ms_time_err, rev_edge, rev_bad;

  ////////////////////////////////////////////////////////////////////////////
  // Control write decode
  assign wr_ctrl = WR && (ADDR == OFS_CTRL);
  assign rst_cmd = wr_ctrl && WDATA[CT_RESET];
  assign cfg_skip = WDATA[CT_SKIP_LO +: 2];
  assign cfg_cnt = WDATA[CT_CNT_LO +: 7];
  assign cfg_sect = WDATA[CT_SECT_LO +: 7];
  // Count of zero or above 64 is refused
  assign cnt_ok = (cfg_cnt != 7'h00) && (cfg_cnt <= MS_MAX_CNT); // see [RULE_14]
  assign ms_start = wr_ctrl && WDATA[CT_START] && !rst_cmd;

  // Multisector end checks
  assign ms_end_err = (ms_r == MS_RUN) && MS_END && (resid_r != 7'h00); // see [RULE_12]
  assign ms_time_err = (ms_r == MS_RUN) && MS_END && (len_r == MS_TIMED_CNT) &&
                       ((ms_tmr_r < 24'(MS_MIN)) || (ms_tmr_r > 24'(MS_MAX))); // see [RULE_15]

  ////////////////////////////////////////////////////////////////////////////
  // Event collection
  always_comb begin
    bs_set = '0;
    cb_set = '0;
    sk_set = '0;
    // Out-of-range sector address
    bs_set[BS_SNF] = SECT_ACC && (SECT_ADDR >= SNF_LO) && (SECT_ADDR <= SNF_HI); // see [RULE_01]
    // Seek past the last cylinder
    if (SEEK_REQ && (SEEK_CYL > MAX_CYL)) begin // see [RULE_02]
      bs_set[BS_FILE] = 1'b1;
      cb_set[CB_FILE] = 1'b1;
      sk_set[SK_CYL] = 1'b1;
    end
    // Control byte sent with even parity
    if (CTL_SEND && !(^{CTL_BYTE, CTL_PAR})) begin // see [RULE_04]
      bs_set[BS_FILE] = 1'b1;
      cb_set[CB_FILE] = 1'b1;
    end
    // Readback checked for even parity
    if (CTL_RB && (^{RB_BYTE, RB_PAR})) begin // see [RULE_05]
      bs_set[BS_PAR] = 1'b1;
      cb_set[CB_PAR] = 1'b1;
    end
    // Diagnostic write collides with a running chain, or a multisector start is refused
    if ((DIAG_WR && CHAIN_BUSY) || (ms_start && (!cnt_ok || ms_r == MS_RUN))) begin // see [RULE_06]
      bs_set[BS_CMD] = 1'b1;
      sk_set[SK_CMD] = 1'b1;
    end
    // Program-controlled interrupt
    if (PCI_ELEM) begin // see [RULE_07]
      bs_set[BS_PCI] = 1'b1;
      cb_set[CB_PCI] = 1'b1;
    end
    // Field checks
    if (ID_CRC_BAD) begin // see [RULE_08]
      bs_set[BS_CRC] = 1'b1;
      bs_set[BS_ID] = 1'b1;
    end
    if (DATA_CRC_BAD) begin // see [RULE_09]
      bs_set[BS_CRC] = 1'b1;
      bs_set[BS_DATA] = 1'b1;
    end
    if (WR_REQ && SECT_PROT) begin // see [RULE_10]
      bs_set[BS_DATA] = 1'b1;
    end
    if (ID_MISMATCH) begin // see [RULE_11]
      bs_set[BS_ID] = 1'b1;
    end
    bs_set[BS_MS] = ms_end_err; // see [RULE_12]
    bs_set[BS_TIME] = ms_time_err;
  end

  // Interrupt sources
  always_comb begin
    is_set = '0;
    is_set[IS_ERR] = |(bs_set & ~(BS_W'(1) << BS_PCI));
    is_set[IS_PCI] = PCI_ELEM;
    is_set[IS_SPEED] = rev_edge && rev_bad;
    is_set[IS_MSDONE] = (ms_r == MS_RUN) && MS_END;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by its own read or by reset command; set wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bs_r <= '0;
      cb_r <= '0;
      sk_r <= '0;
    end else begin
      // Live speed bit is never latched
      bs_r <= (((RD && ADDR == OFS_BASIC) || rst_cmd) ? '0 : bs_r) | bs_set; // see [RULE_18]
      cb_r <= (((RD && ADDR == OFS_CBP) || rst_cmd) ? '0 : cb_r) | cb_set; // see [RULE_18]
      sk_r <= (((RD && ADDR == OFS_SEEK) || rst_cmd) ? '0 : sk_r) | sk_set; // see [RULE_18]
    end
  end

  // Interrupt status and mask
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      is_r <= '0;
      im_r <= IMASK_RST;
    end else begin
      // Write one clears, a new event in the same cycle survives
      is_r <= (is_r & ~((WR && ADDR == OFS_ISTAT) ? WDATA[IS_W-1:0] : '0)) | is_set;
      if (WR && ADDR == OFS_IMASK) begin
        im_r <= WDATA[IS_W-1:0];
      end
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(is_r & im_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (RD) begin
      unique case (ADDR)
        OFS_BASIC: RDATA <= 32'({bs_r[BS_W-1:BS_SPEED+1], SPEED_OK, bs_r[BS_SPEED-1:0]});
        OFS_CBP: RDATA <= 32'(cb_r);
        OFS_SEEK: RDATA <= 32'(sk_r);
        OFS_ISTAT: RDATA <= 32'(is_r);
        OFS_IMASK: RDATA <= 32'(im_r);
        OFS_CTRL: RDATA <= 32'(cfg_sect_hold(next_r));
        OFS_RESID: RDATA <= 32'({ms_r, len_r, resid_r});
        OFS_REV: RDATA <= 32'(rev_last_r);
        // Unmapped offsets read as zero
        default: RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  // Next-sector pointer shown in the sector field of control
  function automatic logic [17:0] cfg_sect_hold(input logic [6:0] s);
    cfg_sect_hold = 18'({s, 7'h00} << 4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Multisector sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_r <= MS_IDLE;
      resid_r <= '0;
      next_r <= '0;
      skip_r <= 7'h01;
      len_r <= '0;
    end else if (rst_cmd) begin
      // Reset command abandons the operation
      ms_r <= MS_IDLE;
      resid_r <= '0;
    end else begin
      unique case (ms_r)
        MS_IDLE: begin
          if (ms_start && cnt_ok) begin // see [RULE_14]
            ms_r <= MS_RUN;
            resid_r <= cfg_cnt;
            len_r <= cfg_cnt;
            next_r <= cfg_sect;
            skip_r <= 7'(7'h01 << cfg_skip);
          end
        end
        MS_RUN: begin
          if (MS_END) begin
            ms_r <= MS_IDLE; // Residual stays readable
          end else begin
            if (MS_SECT_DONE && resid_r != 7'h00) begin
              resid_r <= resid_r - 7'h01;
            end
            if (id_ok(ID_WR_REQ, ID_WR_SECT)) begin // see [RULE_13]
              next_r <= 7'(next_r + skip_r);
            end
          end
        end
      endcase
    end
  end

  // An ID write is let through only for the next scheduled sector
  function automatic logic id_ok(input logic req, input logic [6:0] sect);
    id_ok = req && (ms_r == MS_RUN) && (resid_r != 7'h00) && (sect == next_r) && !MS_END;
  endfunction

  // Operation timer, saturating so a stuck operation still reads as late
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_tmr_r <= '0;
    end else if (ms_r == MS_IDLE) begin
      ms_tmr_r <= 24'h000001;
    end else if (ms_tmr_r != 24'hffffff) begin
      ms_tmr_r <= ms_tmr_r + 24'h000001; // see [RULE_15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gated strobes to the drive side, registered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WR_GATE <= 1'b0;
      ID_WR_GATE <= 1'b0;
      PCI_RETURN <= 1'b0;
      MS_BUSY <= 1'b0;
    end else begin
      WR_GATE <= WR_REQ && !SECT_PROT; // see [RULE_10]
      ID_WR_GATE <= id_ok(ID_WR_REQ, ID_WR_SECT); // see [RULE_13]
      // Chain is not held; only the host is told at once
      PCI_RETURN <= PCI_ELEM; // see [RULE_07]
      MS_BUSY <= (ms_r == MS_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index pin synchroniser and filter; stage 0 feeds stage 1 only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idx_s_r <= '0;
      idx_f_r <= 1'b0;
    end else begin
      idx_s_r <= {idx_s_r[1:0], INDEX_PIN};
      if (idx_s_r[1] == idx_s_r[2]) begin
        idx_f_r <= idx_s_r[2];
      end
    end
  end

  assign rev_edge = (idx_s_r[1] == idx_s_r[2]) && idx_s_r[2] && !idx_f_r;
  assign rev_bad = rev_seen_r && ((rev_r < 24'(REV_MIN)) || (rev_r > 24'(REV_MAX)));

  // Revolution timing between index edges
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rev_r <= '0;
      rev_last_r <= '0;
      rev_seen_r <= 1'b0;
      SPEED_OK <= 1'b0;
    end else if (rev_edge) begin
      rev_r <= 24'h000001;
      rev_last_r <= rev_r;
      rev_seen_r <= 1'b1;
      SPEED_OK <= rev_seen_r && !rev_bad; // see [RULE_16]
    end else begin
      // A lost index also drops the speed indication
      if (rev_r != 24'hffffff) begin
        rev_r <= rev_r + 24'h000001;
      end
      if (rev_r > 24'(REV_MAX)) begin
        SPEED_OK <= 1'b0; // see [RULE_16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sector_range_a: assert property (SECT_ACC && SECT_ADDR >= 7'h42 && !rst_cmd |=> bs_r[BS_SNF]) // see [RULE_01]
    else $error("sector not found missed");
  seek_file_a: assert property (SEEK_REQ && SEEK_CYL > 9'd359 && !rst_cmd |=> bs_r[BS_FILE] && cb_r[CB_FILE]) // see [RULE_02]
    else $error("bad cylinder not flagged");
  send_parity_a: assert property (CTL_SEND && !(^{CTL_BYTE, CTL_PAR}) && !rst_cmd |=> cb_r[CB_FILE]) // see [RULE_04]
    else $error("even parity byte not flagged");
  readback_par_a: assert property (CTL_RB && (^{RB_BYTE, RB_PAR}) && !rst_cmd |=> bs_r[BS_PAR] && cb_r[CB_PAR]) // see [RULE_05]
    else $error("readback parity not flagged");
  diag_busy_a: assert property (DIAG_WR && CHAIN_BUSY && !rst_cmd |=> bs_r[BS_CMD] && sk_r[SK_CMD]) // see [RULE_06]
    else $error("command error missed");
  pci_return_a: assert property (PCI_ELEM |=> PCI_RETURN && is_r[IS_PCI] && cb_r[CB_PCI]) // see [RULE_07]
    else $error("pci return missing");
  crc_pair_a: assert property ((ID_CRC_BAD || DATA_CRC_BAD) && !rst_cmd |=> bs_r[BS_CRC]) // see [RULE_08]
    else $error("crc error missed");
  protect_gate_a: assert property (WR_REQ && SECT_PROT |=> !WR_GATE && (bs_r[BS_DATA] || $past(rst_cmd))) // see [RULE_10]
    else $error("protected write let through");
  resid_end_a: assert property (ms_r == MS_RUN && MS_END && resid_r != 7'h00 && !rst_cmd |=> bs_r[BS_MS]) // see [RULE_12]
    else $error("residual count not flagged");
  id_only_a: assert property (ID_WR_GATE |-> $past(ID_WR_SECT) == $past(next_r) && $past(ms_r) == MS_RUN) // see [RULE_13]
    else $error("unrequested id write");
  latch_hold_a: assert property (bs_r[BS_ID] && !(RD && ADDR == OFS_BASIC) && !rst_cmd |=> bs_r[BS_ID]) // see [RULE_18]
    else $error("status bit dropped");
  read_clear_a: assert property (RD && ADDR == OFS_BASIC && bs_r[BS_SNF] |=> RDATA[BS_SNF]) // see [RULE_18]
    else $error("read lost status bit");

  ms_run_c: cover property (ms_r == MS_RUN && MS_END && resid_r == 7'h00);
  pci_irq_c: cover property (PCI_ELEM ##[1:3] IRQ);
  speed_c: cover property (rev_edge && SPEED_OK);

endmodule

/* File: test/dae_drive_model.sv */
// Purpose: Behavioural disk drive at the far side of the error detection block
// Assumes: Index period is given in CLK cycles; zero stops the spindle
// Notes: Index edges are offset from CLK so the block sees them asynchronously
`timescale 1ns/1ps
module dae_drive_model (
  // Clock and spindle setting
  input wire logic clk,
  input wire logic [15:0] rev_cyc,
  // Seek requests seen by the drive
  input wire logic seek_req,
  input wire logic [8:0] seek_cyl,
  // Drive outputs
  output logic index_pin,
  output logic track_na,
  // Head configuration option byte and its decode
  input wire logic [7:0] opt_byte,
  output logic [3:0] moving_heads,
  output logic [3:0] fixed_heads
);
  logic [15:0] cnt_r = 16'h0; // Position within one revolution
  ////////////////////////////////////////////////////////////////
  // Head layout from the option byte; unknown bytes give no heads
  always_comb begin
    {moving_heads, fixed_heads} = 8'h00;
    case (opt_byte)
      8'h10: {moving_heads, fixed_heads} = 8'h50;
      8'h20: {moving_heads, fixed_heads} = 8'hb0;
      8'h30: {moving_heads, fixed_heads} = 8'h48;
      8'h40: {moving_heads, fixed_heads} = 8'ha8;
      default: ;
    endcase
  end
  ////////////////////////////////////////////////////////////////
  // Index pulse once per revolution, four cycles wide
  always @(posedge clk) begin
    if (rev_cyc == 16'h0) begin // Spindle stopped, no index at all
      cnt_r <= 16'h0;
      index_pin <= #3 1'b0;
    end else begin
      cnt_r <= (cnt_r >= rev_cyc - 16'h1) ? 16'h0 : cnt_r + 16'h1;
      index_pin <= #3 (cnt_r < 16'h4);
    end
  end
  ////////////////////////////////////////////////////////////////
  // Seeks beyond the last cylinder leave the actuator where it is
  always @(posedge clk) begin
    if (seek_req) begin
      track_na <= (seek_cyl > 9'h167);
    end
  end
endmodule

/* File: test/tb_dae_core.sv */
// Purpose: Self-checking bench for the disk adapter error detection block
// Assumes: Shortened revolution and multisector windows (90..110, 40..60)
// Notes: Status bit 9 is live speed, masked out of latched status checks
`timescale 1ns/1ps
module tb_dae_core import dae_pkg::*; ();
  localparam logic [31:0] NOSPD = 32'hffff_fdff; // Hide live speed bit
  logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0] ADDR = 8'h0, CTL_BYTE = 8'h0, RB_BYTE = 8'h0;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic SECT_ACC = 1'b0, SEEK_REQ = 1'b0, CTL_SEND = 1'b0, CTL_PAR = 1'b0, CTL_RB = 1'b0, RB_PAR = 1'b0;
  logic DIAG_WR = 1'b0, CHAIN_BUSY = 1'b0, PCI_ELEM = 1'b0, ID_CRC_BAD = 1'b0, DATA_CRC_BAD = 1'b0;
  logic ID_MISMATCH = 1'b0, WR_REQ = 1'b0, SECT_PROT = 1'b0, MS_SECT_DONE = 1'b0, MS_END = 1'b0;
  logic ID_WR_REQ = 1'b0, INDEX_PIN, IRQ, PCI_RETURN, WR_GATE, ID_WR_GATE, MS_BUSY, SPEED_OK;
  logic [6:0] SECT_ADDR = 7'h0, ID_WR_SECT = 7'h0;
  logic [8:0] SEEK_CYL = 9'h0;
  logic [15:0] rev_cyc = 16'h0; // Spindle stopped until the speed test
  logic [7:0] opt_byte = 8'h0; // Head option byte for the drive
  logic [3:0] mv_heads, fx_heads;
  logic track_na;
  localparam logic [31:0] HEADS = 32'ha848_b050; // Moving and fixed heads, options 10..40
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #12.5 CLK = ~CLK;
  dae_core #(.REV_MIN(90), .REV_MAX(110), .MS_MIN(40), .MS_MAX(60)) dae_core_inst (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .SECT_ACC(SECT_ACC), .SECT_ADDR(SECT_ADDR), .SEEK_REQ(SEEK_REQ), .SEEK_CYL(SEEK_CYL),
    .CTL_SEND(CTL_SEND), .CTL_BYTE(CTL_BYTE), .CTL_PAR(CTL_PAR), .CTL_RB(CTL_RB), .RB_BYTE(RB_BYTE),
    .RB_PAR(RB_PAR), .DIAG_WR(DIAG_WR), .CHAIN_BUSY(CHAIN_BUSY), .PCI_ELEM(PCI_ELEM),
    .PCI_RETURN(PCI_RETURN), .ID_CRC_BAD(ID_CRC_BAD), .DATA_CRC_BAD(DATA_CRC_BAD),
    .ID_MISMATCH(ID_MISMATCH), .WR_REQ(WR_REQ), .SECT_PROT(SECT_PROT), .WR_GATE(WR_GATE),
    .MS_SECT_DONE(MS_SECT_DONE), .MS_END(MS_END), .ID_WR_REQ(ID_WR_REQ), .ID_WR_SECT(ID_WR_SECT),
    .ID_WR_GATE(ID_WR_GATE), .MS_BUSY(MS_BUSY), .INDEX_PIN(INDEX_PIN), .SPEED_OK(SPEED_OK));
  dae_drive_model dae_drive_model_inst (.clk(CLK), .rev_cyc(rev_cyc), .seek_req(SEEK_REQ),
    .seek_cyl(SEEK_CYL), .index_pin(INDEX_PIN), .track_na(track_na), .opt_byte(opt_byte),
    .moving_heads(mv_heads), .fixed_heads(fx_heads));
  ////////////////////////////////////////////////////////////////
  // Compare, report and close
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the roughly 1300 cycles the tests need
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Register port and event pulses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk($sformatf("reg %h", a), RDATA & msk, exp);
  endtask
  // Drop every event strobe one cycle after it rose
  task automatic clr();
    @(posedge CLK);
    {SECT_ACC, SEEK_REQ, CTL_SEND, CTL_RB, DIAG_WR, PCI_ELEM, ID_CRC_BAD} <= 7'h0;
    {DATA_CRC_BAD, ID_MISMATCH, WR_REQ, MS_SECT_DONE, MS_END, ID_WR_REQ} <= 6'h0;
  endtask
  task automatic id_wr(input logic [6:0] s, input logic exp);
    @(posedge CLK);
    ID_WR_SECT <= s; ID_WR_REQ <= 1'b1;
    clr();
    #1 chk("id write gate", {31'h0, ID_WR_GATE}, {31'h0, exp});
  endtask
  ////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    rd_chk(OFS_IMASK, 32'h0, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0, 32'hffff_ffff); // Unmapped place reads zero
    for (int s = 'h3f; s < 'h80; s++) begin
      @(posedge CLK);
      SECT_ADDR <= 7'(s); SECT_ACC <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, {31'h0, s >= 'h42}, NOSPD);
    end
    for (int c = 0; c < 3; c++) begin
      @(posedge CLK);
      SEEK_CYL <= (c == 0) ? 9'h167 : ((c == 1) ? 9'h168 : 9'h1ff); SEEK_REQ <= 1'b1;
      clr();
      #1 chk("track na", {31'h0, track_na}, {31'h0, c > 0});
      rd_chk(OFS_BASIC, (c > 0) ? 32'h2 : 32'h0, NOSPD);
      rd_chk(OFS_CBP, (c > 0) ? 32'h1 : 32'h0, 32'hffff_ffff);
      rd_chk(OFS_SEEK, (c > 0) ? 32'h2 : 32'h0, 32'hffff_ffff);
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge CLK);
      CTL_BYTE <= 8'h03; CTL_PAR <= p[0]; CTL_SEND <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, p ? 32'h0 : 32'h2, NOSPD);
      rd_chk(OFS_CBP, p ? 32'h0 : 32'h1, 32'hffff_ffff);
      @(posedge CLK);
      RB_BYTE <= 8'h01; RB_PAR <= p[0]; CTL_RB <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, p ? 32'h0 : 32'h80, NOSPD);
      rd_chk(OFS_CBP, p ? 32'h0 : 32'h2, 32'hffff_ffff);
      @(posedge CLK);
      CHAIN_BUSY <= p[0]; DIAG_WR <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, p ? 32'h40 : 32'h0, NOSPD);
      rd_chk(OFS_SEEK, {31'h0, p[0]}, 32'hffff_ffff);
      @(posedge CLK);
      SECT_PROT <= p[0]; WR_REQ <= 1'b1;
      clr();
      #1 chk("write gate", {31'h0, WR_GATE}, {31'h0, !p[0]});
      rd_chk(OFS_BASIC, p ? 32'h10 : 32'h0, NOSPD);
    end
    $display("test single events done");
    @(posedge CLK);
    PCI_ELEM <= 1'b1;
    clr();
    #1 chk("pci return", {31'h0, PCI_RETURN}, 32'h1);
    rd_chk(OFS_CBP, 32'h4, 32'hffff_ffff);
    @(posedge CLK);
    ID_CRC_BAD <= 1'b1;
    clr();
    rd_chk(OFS_BASIC, 32'h10c, NOSPD);
    @(posedge CLK);
    DATA_CRC_BAD <= 1'b1;
    clr();
    rd_chk(OFS_BASIC, 32'h14, NOSPD);
    @(posedge CLK);
    ID_MISMATCH <= 1'b1;
    clr();
    #1 chk("irq masked", {31'h0, IRQ}, 32'h0);
    rd_chk(OFS_BASIC, 32'h8, NOSPD);
    rd_chk(OFS_BASIC, 32'h0, NOSPD);
    wr(OFS_IMASK, 32'h1);
    repeat (2) @(posedge CLK);
    #1 chk("irq raised", {31'h0, IRQ}, 32'h1);
    wr(OFS_ISTAT, 32'hf);
    repeat (2) @(posedge CLK);
    #1 chk("irq cleared", {31'h0, IRQ}, 32'h0);
    @(posedge CLK);
    ID_MISMATCH <= 1'b1;
    clr();
    wr(OFS_CTRL, 32'h1);
    rd_chk(OFS_BASIC, 32'h0, NOSPD);
    $display("test latching and interrupt done");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL, 32'h22 | (k << 2));
      repeat (2) @(posedge CLK);
      #1 chk("ms busy", {31'h0, MS_BUSY}, 32'h1);
      id_wr(7'h0, 1'b1);
      id_wr(7'h3, 1'b0);
      rd_chk(OFS_CTRL, (32'h1 << k) << 11, 32'h3f800);
      for (int n = 0; n < 2; n++) begin
        @(posedge CLK);
        MS_SECT_DONE <= 1'b1;
        clr();
      end
      @(posedge CLK);
      MS_END <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, 32'h0, NOSPD);
    end
    for (int n = 64; n < 66; n++) begin
      wr(OFS_CTRL, (n << 4) | 32'h2);
      repeat (4) @(posedge CLK);
      MS_END <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, (n == 64) ? 32'h20 : 32'h40, NOSPD);
    end
    // Too short a 32-sector read, then one inside the window
    for (int t = 4; t < 60; t += 44) begin
      wr(OFS_CTRL, 32'h202);
      repeat (t) @(posedge CLK);
      MS_END <= 1'b1;
      clr();
      rd_chk(OFS_BASIC, (t == 4) ? 32'h420 : 32'h20, NOSPD);
    end
    $display("test multisector done");
    rev_cyc <= 16'd100;
    repeat (400) @(posedge CLK);
    #1 chk("speed ok", {31'h0, SPEED_OK}, 32'h1);
    rev_cyc <= 16'd150;
    repeat (400) @(posedge CLK);
    #1 chk("speed low", {31'h0, SPEED_OK}, 32'h0);
    for (int h = 0; h < 4; h++) begin
      @(posedge CLK);
      opt_byte <= 8'(h * 16 + 16);
      #1 chk("heads", {24'h0, mv_heads, fx_heads}, {24'h0, HEADS[8 * h +: 8]});
    end
    $display("test speed and heads done");
    test_done();
  end
endmodule
